/* File: hw/emr_regs_top.sv */
// configuration memory and phy management register front end
`timescale 1ns/1ps
`default_nettype none
`include "emr_consts.svh"
module emr_regs_top
   import emr_pkg::*;
(
   input  wire logic          i_mclk,
   input  wire logic          i_reset_n,
   // network side register port
   input  wire logic          i_net_req,
   input  wire logic          i_net_we,
   input  wire logic [15:0]   i_net_addr,
   input  wire logic [3:0]    i_net_be,
   input  wire logic [31:0]   i_net_wdata,
   output logic [31:0]        o_net_rdata,
   output logic               o_net_rvalid,
   // local host side register port
   input  wire logic          i_host_req,
   input  wire logic          i_host_we,
   input  wire logic [15:0]   i_host_addr,
   input  wire logic [3:0]    i_host_be,
   input  wire logic [31:0]   i_host_wdata,
   output logic [31:0]        o_host_rdata,
   output logic               o_host_rvalid,
   // memory control logic
   input  wire logic          i_mem_busy,
   input  wire logic          i_mem_host_owns,
   input  wire logic          i_mem_two_byte_addr,
   input  wire logic          i_mem_emulation,
   input  wire logic          i_mem_rd_valid,
   input  wire logic [31:0]   i_mem_rd_data,
   output logic [31:0]        o_mem_word_addr,
   output logic [15:0]        o_memory_write_low,
   // phy management
   input  wire logic          i_frame_start,
   input  wire logic          i_mi_host_owns,
   input  wire logic          i_host_side_takeover_allowed,
   input  wire logic          i_mii_link_cfg,
   input  wire logic [4:0]    i_first_port_phy_addr,
   input  wire logic          i_mii_done,
   input  wire logic          i_mii_read_fail,
   output logic               o_mii_start,
   output logic [1:0]         o_mii_cmd
);
   localparam int NP = 2;
   localparam int NET = 0;
   localparam int HOST = 1;

   emr_mgmt_if                mi ();

   logic [NP-1:0]             p_req;
   logic [NP-1:0]             p_we;
   logic [15:0]               p_addr [NP];
   logic [3:0]                p_be [NP];
   logic [31:0]               p_wdata [NP];
   logic [31:0]               rdata_q [NP];
   logic [NP-1:0]             rvalid_q;
   logic [NP-1:0]             wr_addr;
   logic [NP-1:0]             wr_data;
   logic [NP-1:0]             wr_cs;
   logic [NP-1:0]             wr_cs_hi;
   logic [NP-1:0]             is_owner;

   logic [31:0]               addr_q;
   logic [15:0]               data_hi_q;
   logic [15:0]               data_lo_q;
   logic                      permit_q;
   logic                      permit_eff;
   logic [15:0]               cs_rd;
   logic [31:0]               addr_mask;

   assign p_req[NET]    = i_net_req;
   assign p_we[NET]     = i_net_we;
   assign p_addr[NET]   = i_net_addr;
   assign p_be[NET]     = i_net_be;
   assign p_wdata[NET]  = i_net_wdata;
   assign p_req[HOST]   = i_host_req;
   assign p_we[HOST]    = i_host_we;
   assign p_addr[HOST]  = i_host_addr;
   assign p_be[HOST]    = i_host_be;
   assign p_wdata[HOST] = i_host_wdata;

   assign is_owner[NET]  = !i_mem_host_owns;
   assign is_owner[HOST] = i_mem_host_owns;

   // control/status view, reserved bits 12..10 read zero
   always_comb
   begin
      cs_rd = `EMR_RST_HALF;
      cs_rd[`EMR_CS_BUSY] = mi.busy;
      cs_rd[`EMR_CS_CMD_ERR] = mi.cmd_err;
      cs_rd[`EMR_CS_RD_FAULT] = mi.rd_fault;
      cs_rd[`EMR_CS_CMD_HI:`EMR_CS_CMD_LO] = mi.cmd_q;
      cs_rd[`EMR_CS_PHYA_HI:`EMR_CS_PHYA_LO] = i_first_port_phy_addr;
      cs_rd[`EMR_CS_LINK_CFG] = i_mii_link_cfg;
      cs_rd[`EMR_CS_TAKEOVER] = i_host_side_takeover_allowed;
      cs_rd[`EMR_CS_WR_PERMIT] = permit_eff;
   end

   genvar gp;
   generate
      for (gp = 0; gp < NP; gp++)
      begin : g_party
         // address register only as an aligned full word
         assign wr_addr[gp] = p_req[gp] && p_we[gp] &&
                              (p_addr[gp] == `EMR_OFF_MEM_ADDR) &&
                              (p_be[gp] == `EMR_BE_ALL) &&
                              is_owner[gp] &&
                              !i_mem_busy;
         assign wr_data[gp] = p_req[gp] && p_we[gp] &&
                              (p_addr[gp] == `EMR_OFF_MEM_DATA);
         assign wr_cs[gp]   = p_req[gp] && p_we[gp] &&
                              (p_addr[gp] == `EMR_OFF_MI_CS);
         assign wr_cs_hi[gp] = wr_cs[gp] && p_be[gp][`EMR_LANE_CS_HI];

         // one-cycle read latency; unmapped offsets read zero
         always_ff @(posedge i_mclk)
         begin
            if (!i_reset_n)
               rdata_q[gp] <= `EMR_RST_WORD;
            else if (p_req[gp] && !p_we[gp])
            begin
               case (p_addr[gp])
                  `EMR_OFF_MEM_ADDR: rdata_q[gp] <= addr_q;
                  `EMR_OFF_MEM_DATA: rdata_q[gp] <= {data_hi_q, data_lo_q};
                  `EMR_OFF_MI_CS:    rdata_q[gp] <= {`EMR_RST_HALF, cs_rd};
                  default:           rdata_q[gp] <= `EMR_RST_WORD;
               endcase
            end
         end

         always_ff @(posedge i_mclk)
         begin
            if (!i_reset_n)
               rvalid_q[gp] <= 1'b0;
            else
               rvalid_q[gp] <= p_req[gp] && !p_we[gp];
         end
      end
   endgenerate

   assign o_net_rdata   = rdata_q[NET];
   assign o_host_rdata  = rdata_q[HOST];
   assign o_net_rvalid  = rvalid_q[NET];
   assign o_host_rvalid = rvalid_q[HOST];

   // only one side owns the memory, so at most one write lands
   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
         addr_q <= `EMR_RST_WORD;
      else if (wr_addr[HOST])
         addr_q <= p_wdata[HOST];
      else if (wr_addr[NET])
         addr_q <= p_wdata[NET];
   end

   // word index, trimmed to what the memory size uses
   always_comb
   begin
      if (i_mem_emulation)
         addr_mask = `EMR_MASK_EMU;
      else if (i_mem_two_byte_addr)
         addr_mask = `EMR_MASK_LARGE;
      else
         addr_mask = `EMR_MASK_SMALL;
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
         o_mem_word_addr <= `EMR_RST_WORD;
      else
         o_mem_word_addr <= addr_q & addr_mask;
   end

   // returned memory data takes precedence over a same-cycle write
   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
         data_hi_q <= `EMR_RST_HALF;
      else if (i_mem_rd_valid)
         data_hi_q <= i_mem_rd_data[31:16];
      else if (wr_data[HOST])
      begin
         if (p_be[HOST][`EMR_LANE_DATA_HI0])
            data_hi_q[7:0] <= p_wdata[HOST][23:16];
         if (p_be[HOST][`EMR_LANE_DATA_HI1])
            data_hi_q[15:8] <= p_wdata[HOST][31:24];
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
         data_lo_q <= `EMR_RST_HALF;
      else if (i_mem_rd_valid)
         data_lo_q <= i_mem_rd_data[15:0];
      else
      begin
         // host lanes written last so they win a collision
         if (wr_data[NET] && p_be[NET][`EMR_LANE_DATA_LO0])
            data_lo_q[7:0] <= p_wdata[NET][7:0];
         if (wr_data[NET] && p_be[NET][`EMR_LANE_DATA_LO1])
            data_lo_q[15:8] <= p_wdata[NET][15:8];
         if (wr_data[HOST] && p_be[HOST][`EMR_LANE_DATA_LO0])
            data_lo_q[7:0] <= p_wdata[HOST][7:0];
         if (wr_data[HOST] && p_be[HOST][`EMR_LANE_DATA_LO1])
            data_lo_q[15:8] <= p_wdata[HOST][15:8];
      end
   end

   assign o_memory_write_low = data_lo_q;

   // permit is written by the network side only; a write beats sof
   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
         permit_q <= 1'b0;
      else if (wr_cs[NET] && p_be[NET][`EMR_LANE_CS_LO])
         permit_q <= p_wdata[NET][`EMR_CS_WR_PERMIT];
      else if (i_frame_start)
         permit_q <= 1'b0;
   end

   assign permit_eff = permit_q || i_mi_host_owns;

   // command write: host wins if both sides write the same cycle
   assign mi.cmd_wr    = |wr_cs_hi;
   assign mi.cmd_code  = wr_cs_hi[HOST] ?
                         p_wdata[HOST][`EMR_CS_CMD_HI:`EMR_CS_CMD_LO] :
                         p_wdata[NET][`EMR_CS_CMD_HI:`EMR_CS_CMD_LO];
   assign mi.ctl_hi_wr = |wr_cs_hi;
   assign mi.wr_permit = permit_eff;

   emr_mgmt_ctrl u_ctrl
   (
      .i_mclk          (i_mclk),
      .i_reset_n       (i_reset_n),
      .bus             (mi),
      .i_mii_done      (i_mii_done),
      .i_mii_read_fail (i_mii_read_fail),
      .o_mii_start     (o_mii_start),
      .o_mii_cmd       (o_mii_cmd)
   );
endmodule
`default_nettype wire

/* File: hw/emr_consts.svh */
// offsets, field positions and reset values of the management registers
`ifndef EMR_CONSTS_SVH
`define EMR_CONSTS_SVH

`define EMR_OFF_MEM_ADDR   16'h0504
`define EMR_OFF_MEM_DATA   16'h0508
`define EMR_OFF_MI_CS      16'h0510

`define EMR_RST_WORD       32'h0000_0000
`define EMR_RST_HALF       16'h0000
`define EMR_RST_CMD        2'h0

`define EMR_MASK_SMALL     32'h0000_03ff
`define EMR_MASK_LARGE     32'h0003_ffff
`define EMR_MASK_EMU       32'hffff_ffff

`define EMR_BE_ALL         4'hf
`define EMR_LANE_CS_LO     0
`define EMR_LANE_CS_HI     1
`define EMR_LANE_DATA_LO0  0
`define EMR_LANE_DATA_LO1  1
`define EMR_LANE_DATA_HI0  2
`define EMR_LANE_DATA_HI1  3

`define EMR_CS_BUSY        15
`define EMR_CS_CMD_ERR     14
`define EMR_CS_RD_FAULT    13
`define EMR_CS_CMD_HI      9
`define EMR_CS_CMD_LO      8
`define EMR_CS_PHYA_HI     7
`define EMR_CS_PHYA_LO     3
`define EMR_CS_LINK_CFG    2
`define EMR_CS_TAKEOVER    1
`define EMR_CS_WR_PERMIT   0

`endif

/* File: hw/emr_pkg.sv */
// types shared by the management register front end
package emr_pkg;
   typedef enum logic [1:0]
   {
      EMR_CMD_IDLE  = 2'h0,
      EMR_CMD_READ  = 2'h1,
      EMR_CMD_WRITE = 2'h2,
      EMR_CMD_RSVD  = 2'h3
   } emr_cmd_t;

   typedef enum logic
   {
      EMR_ST_IDLE = 1'h0,
      EMR_ST_BUSY = 1'h1
   } emr_state_t;
endpackage

/* File: hw/emr_mgmt_if.sv */
// carrier between register decode and the management command engine
`timescale 1ns/1ps
`default_nettype none
interface emr_mgmt_if;
   logic                cmd_wr;
   logic [1:0]          cmd_code;
   logic                ctl_hi_wr;
   logic                wr_permit;
   logic                busy;
   logic [1:0]          cmd_q;
   logic                cmd_err;
   logic                rd_fault;

   modport regs
   (
      output cmd_wr,
      output cmd_code,
      output ctl_hi_wr,
      output wr_permit,
      input  busy,
      input  cmd_q,
      input  cmd_err,
      input  rd_fault
   );

   modport ctrl
   (
      input  cmd_wr,
      input  cmd_code,
      input  ctl_hi_wr,
      input  wr_permit,
      output busy,
      output cmd_q,
      output cmd_err,
      output rd_fault
   );
endinterface
`default_nettype wire

/* File: hw/emr_mgmt_ctrl.sv */
// phy management command engine: busy, command field and error flags
`timescale 1ns/1ps
`default_nettype none
`include "emr_consts.svh"
module emr_mgmt_ctrl
   import emr_pkg::*;
(
   input  wire logic    i_mclk,
   input  wire logic    i_reset_n,
   emr_mgmt_if.ctrl     bus,
   input  wire logic    i_mii_done,
   input  wire logic    i_mii_read_fail,
   output logic         o_mii_start,
   output logic [1:0]   o_mii_cmd
);
   emr_state_t          state_q;
   logic [1:0]          cmd_q;
   logic                err_q;
   logic                fault_q;
   logic                take;
   logic                launch;
   logic                finish;

   // commands arriving while busy are dropped
   assign take   = bus.cmd_wr && (state_q == EMR_ST_IDLE);
   assign launch = take && ((bus.cmd_code == EMR_CMD_READ) ||
                   ((bus.cmd_code == EMR_CMD_WRITE) && bus.wr_permit));
   assign finish = (state_q == EMR_ST_BUSY) && i_mii_done;

   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
         state_q <= EMR_ST_IDLE;
      else
      begin
         case (state_q)
            EMR_ST_IDLE:
            begin
               if (launch)
                  state_q <= EMR_ST_BUSY;
            end
            EMR_ST_BUSY:
            begin
               if (i_mii_done)
                  state_q <= EMR_ST_IDLE;
            end
            default:
               state_q <= EMR_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
         cmd_q <= `EMR_RST_CMD;
      else if (launch)
         cmd_q <= bus.cmd_code;
      else if (finish)
         cmd_q <= EMR_CMD_IDLE;
   end

   // error result decided when the command is taken
   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
         err_q <= 1'b0;
      else if (take)
      begin
         case (bus.cmd_code)
            EMR_CMD_IDLE:  err_q <= 1'b0;
            EMR_CMD_READ:  err_q <= 1'b0;
            EMR_CMD_WRITE: err_q <= !bus.wr_permit;
            default:       err_q <= 1'b1;
         endcase
      end
   end

   // a failure at completion beats a same-cycle clear
   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
         fault_q <= 1'b0;
      else if (finish && (cmd_q == EMR_CMD_READ) && i_mii_read_fail)
         fault_q <= 1'b1;
      else if (bus.ctl_hi_wr)
         fault_q <= 1'b0;
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_reset_n)
         o_mii_start <= 1'b0;
      else
         o_mii_start <= launch;
   end

   assign o_mii_cmd    = cmd_q;
   assign bus.busy     = (state_q == EMR_ST_BUSY);
   assign bus.cmd_q    = cmd_q;
   assign bus.cmd_err  = err_q;
   assign bus.rd_fault = fault_q;
endmodule
`default_nettype wire

/* File: verification/emr_phy_model.sv */
// phy management port model answering the command engine
`timescale 1ns/1ps
`default_nettype none
module emr_phy_model
(
   input  wire logic       i_mclk,
   input  wire logic       i_reset_n,
   input  wire logic       i_start,
   input  wire logic [1:0] i_cmd,
   input  wire logic [7:0] i_delay,
   input  wire logic       i_fail,
   output logic            o_done,
   output logic            o_fail
);
   logic [7:0] cnt_q;
   logic       run_q;
   logic       rd_q;

   always_ff @(posedge i_mclk)
   begin
      o_done <= 1'b0;
      // fail is only qualified by done, so it wobbles otherwise
      o_fail <= ~o_fail;
      if (!i_reset_n)
      begin
         run_q  <= 1'b0;
         o_fail <= 1'b0;
      end
      else if (i_start)
      begin
         run_q <= 1'b1;
         cnt_q <= i_delay;
         rd_q  <= (i_cmd == 2'h1);
      end
      else if (run_q && cnt_q == 8'h0)
      begin
         run_q  <= 1'b0;
         o_done <= 1'b1;
         o_fail <= rd_q & i_fail;  // only reads can fail
      end
      else if (run_q)
         cnt_q <= cnt_q - 8'h1;
   end
endmodule
`default_nettype wire

/* File: verification/emr_regs_chk.sv */
// assertion checker for the management register front end
`timescale 1ns/1ps
`default_nettype none
module emr_regs_chk
(
   input wire logic        i_mclk,
   input wire logic        i_reset_n,
   input wire logic        i_net_req,
   input wire logic        i_net_we,
   input wire logic        o_net_rvalid,
   input wire logic        i_host_req,
   input wire logic        i_host_we,
   input wire logic [15:0] i_host_addr,
   input wire logic [3:0]  i_host_be,
   input wire logic [31:0] i_host_wdata,
   input wire logic        o_host_rvalid,
   input wire logic        i_mem_busy,
   input wire logic        i_mem_two_byte_addr,
   input wire logic        i_mem_emulation,
   input wire logic        i_mem_rd_valid,
   input wire logic [31:0] i_mem_rd_data,
   input wire logic [31:0] o_mem_word_addr,
   input wire logic [15:0] o_memory_write_low,
   input wire logic        i_mi_host_owns,
   input wire logic        i_mii_done,
   input wire logic        o_mii_start,
   input wire logic [1:0]  o_mii_cmd
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_reset_n);

   // host command write taken while the engine is idle
   sequence s_hcmd(logic [1:0] c);
      i_host_req && i_host_we && i_host_addr == 16'h0510 && i_host_be[1]
         && i_host_wdata[9:8] == c && o_mii_cmd == 2'h0;
   endsequence

   AST_RST_VAL: assert property ($rose(i_reset_n) |->
      o_mem_word_addr == 32'h0 && o_mii_cmd == 2'h0 && !o_mii_start)
      else $error("outputs not cleared by reset");
   AST_RD_START: assert property (s_hcmd(2'h1) |=>
      o_mii_start && o_mii_cmd == 2'h1)
      else $error("read command did not start");
   AST_WR_OWN: assert property (s_hcmd(2'h2) ##0 i_mi_host_owns |=>
      o_mii_start && o_mii_cmd == 2'h2)
      else $error("write under host control did not start");
   AST_RSVD: assert property (s_hcmd(2'h3) |=>
      !o_mii_start && o_mii_cmd == 2'h0)
      else $error("reserved command started");
   AST_BUSY_HOLD: assert property (o_mii_cmd != 2'h0 && !i_mii_done |=>
      !o_mii_start && $stable(o_mii_cmd))
      else $error("command disturbed while busy");
   AST_DONE: assert property (o_mii_cmd != 2'h0 && i_mii_done |=>
      o_mii_cmd == 2'h0 && !o_mii_start)
      else $error("command not cleared at completion");
   AST_ADDR_BUSY: assert property ($past(i_mem_busy) && i_mem_busy
      && $stable({i_mem_two_byte_addr, i_mem_emulation})
      |=> $stable(o_mem_word_addr))
      else $error("address changed while memory busy");
   AST_ADDR_MASK: assert property (!$past(i_mem_emulation)
      && !$past(i_mem_two_byte_addr) |-> o_mem_word_addr[31:10] == 22'h0)
      else $error("small memory address wider than ten bits");
   AST_DATA_LOAD: assert property (i_mem_rd_valid |=>
      {16'h0, o_memory_write_low} == ($past(i_mem_rd_data) & 32'hffff))
      else $error("memory read data not loaded");
   AST_NET_RD: assert property (i_net_req && !i_net_we |=> o_net_rvalid)
      else $error("network read not answered");
   AST_HOST_RD: assert property (i_host_req && !i_host_we |=> o_host_rvalid)
      else $error("host read not answered");
endmodule

bind emr_regs_top emr_regs_chk emr_regs_chk_inst
(
   .i_mclk, .i_reset_n, .i_net_req, .i_net_we, .o_net_rvalid,
   .i_host_req, .i_host_we, .i_host_addr, .i_host_be, .i_host_wdata,
   .o_host_rvalid, .i_mem_busy, .i_mem_two_byte_addr, .i_mem_emulation,
   .i_mem_rd_valid, .i_mem_rd_data, .o_mem_word_addr, .o_memory_write_low,
   .i_mi_host_owns, .i_mii_done, .o_mii_start, .o_mii_cmd
);
`default_nettype wire

/* File: verification/test_emr_regs_top.sv */
// self-checking bench for the management register front end
`timescale 1ns/1ps
`default_nettype none
`include "emr_consts.svh"
module test_emr_regs_top;
   logic        i_mclk, i_reset_n = 1'b0;
   logic        i_net_req = 1'b0, i_net_we = 1'b0;
   logic        i_host_req = 1'b0, i_host_we = 1'b0;
   logic [15:0] i_net_addr = '0, i_host_addr = '0;
   logic [3:0]  i_net_be = '0, i_host_be = '0;
   logic [31:0] i_net_wdata = '0, i_host_wdata = '0, i_mem_rd_data = '0;
   logic        i_mem_busy = 1'b0, i_mem_host_owns = 1'b0;
   logic        i_mem_two_byte_addr = 1'b0, i_mem_emulation = 1'b0;
   logic        i_mem_rd_valid = 1'b0, i_frame_start = 1'b0;
   logic        i_mi_host_owns = 1'b0, i_mii_link_cfg = 1'b0;
   logic        i_host_side_takeover_allowed = 1'b0;
   logic [4:0]  i_first_port_phy_addr = '0;
   logic        i_mii_done, i_mii_read_fail, o_mii_start;
   logic        o_net_rvalid, o_host_rvalid;
   logic [31:0] o_net_rdata, o_host_rdata, o_mem_word_addr;
   logic [15:0] o_memory_write_low;
   logic [1:0]  o_mii_cmd;
   logic [7:0]  dly = 8'd3;
   logic        fl = 1'b1;
   logic [32:0] rdv;
   int          error_cnt = 0, check_count = 0, cyc = 0;
   logic [15:0] offs [4] = '{16'h0504, 16'h0508, 16'h0510, 16'h0500};
   logic [31:0] msk [3] = '{32'h3ff, 32'h3ffff, 32'hffff_ffff};
   logic [1:0]  cc [5] = '{2'h2, 2'h0, 2'h3, 2'h1, 2'h3};
   logic [31:0] ce [5] = '{32'h4000, 32'h0, 32'h4000, 32'h2000, 32'h4000};

   emr_regs_top emr_regs_top_inst
   (
      .i_mclk, .i_reset_n, .i_net_req, .i_net_we, .i_net_addr, .i_net_be,
      .i_net_wdata, .o_net_rdata, .o_net_rvalid, .i_host_req, .i_host_we,
      .i_host_addr, .i_host_be, .i_host_wdata, .o_host_rdata, .o_host_rvalid,
      .i_mem_busy, .i_mem_host_owns, .i_mem_two_byte_addr, .i_mem_emulation,
      .i_mem_rd_valid, .i_mem_rd_data, .o_mem_word_addr, .o_memory_write_low,
      .i_frame_start, .i_mi_host_owns, .i_host_side_takeover_allowed,
      .i_mii_link_cfg, .i_first_port_phy_addr, .i_mii_done,
      .i_mii_read_fail, .o_mii_start, .o_mii_cmd
   );

   emr_phy_model emr_phy_model_inst
   (
      .i_mclk, .i_reset_n, .i_start(o_mii_start), .i_cmd(o_mii_cmd),
      .i_delay(dly), .i_fail(fl), .o_done(i_mii_done),
      .o_fail(i_mii_read_fail)
   );

   initial
   begin
      i_mclk = 1'b0;
      forever #2.5 i_mclk = ~i_mclk;
   end

   task automatic final_report();
      if (error_cnt == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // runs are short; a hung wait ends here
   always @(posedge i_mclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         final_report();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one access; read answer captured one cycle after the request
   task automatic acc(input int s, input logic w, input logic [15:0] a,
                      input logic [3:0] b, input logic [31:0] d);
      @(negedge i_mclk);
      if (s == 1)
         {i_host_req, i_host_we, i_host_addr, i_host_be, i_host_wdata} =
            {1'b1, w, a, b, d};
      else
         {i_net_req, i_net_we, i_net_addr, i_net_be, i_net_wdata} =
            {1'b1, w, a, b, d};
      @(negedge i_mclk);
      i_host_req = 1'b0;
      i_net_req = 1'b0;
      rdv = (s == 1) ? {o_host_rvalid, o_host_rdata} : {o_net_rvalid, o_net_rdata};
   endtask

   task automatic rd(input int s, input logic [15:0] a,
                     input logic [31:0] m, input logic [31:0] e);
      acc(s, 1'b0, a, 4'hf, 32'h0);
      chk({31'h0, rdv[32]}, 32'h1);
      chk(rdv[31:0] & m, e);
   endtask

   task automatic aw(input int s, input logic [3:0] b, input logic [31:0] d, e);
      acc(s, 1'b1, `EMR_OFF_MEM_ADDR, b, d);
      rd(s, `EMR_OFF_MEM_ADDR, 32'hffff_ffff, e);
   endtask

   task automatic idle();
      for (int n = 0; n < 100 && o_mii_cmd !== 2'h0; n++)
         @(negedge i_mclk);
      chk({30'h0, o_mii_cmd}, 32'h0);
   endtask

   // command write on lane 1, then status after the engine settles
   task automatic cmd(input int s, input logic [1:0] c, input logic [31:0] e);
      acc(s, 1'b1, `EMR_OFF_MI_CS, 4'h2, {22'h0, c, 8'h0});
      idle();
      rd(s, `EMR_OFF_MI_CS, 32'he301, e);
   endtask

   initial
   begin
      repeat (20) @(negedge i_mclk);
      i_reset_n = 1'b1;
      for (int s = 0; s < 2; s++)
         foreach (offs[k])
            rd(s, offs[k], 32'hffff_ffff, 32'h0);
      i_mem_host_owns = 1'b1;
      aw(1, 4'hf, 32'hffff_ffff, 32'hffff_ffff);
      for (int k = 0; k < 3; k++)
      begin
         {i_mem_emulation, i_mem_two_byte_addr} = 2'(k);
         repeat (2) @(negedge i_mclk);
         chk(o_mem_word_addr, msk[k]);
      end
      aw(0, 4'hf, 32'h1, 32'hffff_ffff);
      aw(1, 4'h3, 32'h2, 32'hffff_ffff);
      i_mem_busy = 1'b1;
      aw(1, 4'hf, 32'h3, 32'hffff_ffff);
      i_mem_busy = 1'b0;
      i_mem_host_owns = 1'b0;
      aw(0, 4'hf, 32'h1, 32'h1);
      repeat (2) @(negedge i_mclk);
      chk(o_mem_word_addr, 32'h1);
      acc(1, 1'b1, `EMR_OFF_MEM_DATA, 4'hf, 32'h1234_5678);
      acc(0, 1'b1, `EMR_OFF_MEM_DATA, 4'hf, 32'haaaa_5555);
      rd(0, `EMR_OFF_MEM_DATA, 32'hffff_ffff, 32'h1234_5555);
      chk({16'h0, o_memory_write_low}, 32'h5555);
      i_mem_rd_data = 32'hcafe_beef;
      i_mem_rd_valid = 1'b1;
      @(negedge i_mclk);
      i_mem_rd_valid = 1'b0;
      rd(1, `EMR_OFF_MEM_DATA, 32'hffff_ffff, 32'hcafe_beef);
      i_first_port_phy_addr = 5'h15;
      i_mii_link_cfg = 1'b1;
      i_host_side_takeover_allowed = 1'b1;
      acc(1, 1'b1, `EMR_OFF_MI_CS, 4'h1, 32'h1);
      rd(1, `EMR_OFF_MI_CS, 32'hffff_ffff, 32'hae);
      foreach (cc[k])
         cmd(0, cc[k], ce[k]);
      acc(0, 1'b1, `EMR_OFF_MI_CS, 4'h1, 32'h1);
      cmd(0, 2'h2, 32'h1);
      i_frame_start = 1'b1;
      @(negedge i_mclk);
      i_frame_start = 1'b0;
      rd(0, `EMR_OFF_MI_CS, 32'h1, 32'h0);
      i_mi_host_owns = 1'b1;
      rd(0, `EMR_OFF_MI_CS, 32'h1, 32'h1);
      cmd(1, 2'h2, 32'h1);
      cmd(1, 2'h3, 32'h4001);
      dly = 8'd20;
      fl = 1'b0;
      acc(1, 1'b1, `EMR_OFF_MI_CS, 4'h2, 32'h100);
      acc(0, 1'b1, `EMR_OFF_MI_CS, 4'h2, 32'h200);
      rd(0, `EMR_OFF_MI_CS, 32'he300, 32'h8100);
      idle();
      rd(0, `EMR_OFF_MI_CS, 32'he300, 32'h0);
      final_report();
   end
endmodule
`default_nettype wire
